/* File: include/srf_pkg.sv */
/*
 * constants for the serial receive message framer: timing, end codes,
 * storage size and flow control.
 * assumes a single 125 MHz module clock.
 */
package srf_pkg;
  localparam int CLK_NS = 8;
  // idle gap timer unit, one tick per microsecond
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] CODE_DEF = 16'h0d0a;
  localparam logic [15:0] CODE_NONE = 16'hffff;
  localparam logic [9:0] COUNT_DEF = 10'h1ff;
  localparam int AREA_WORDS = 512;
  localparam int FIFO_DEPTH = 4;
  // free staging words at or below which the sender is paused
  localparam int PAUSE_FREE = 1;
  localparam logic [7:0] DC1_CODE = 8'h11;
  localparam logic [7:0] DC3_CODE = 8'h13;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  typedef enum logic {SRF_COLLECT, SRF_HOLD} srf_state_e;
endpackage

/* File: core/srf_fifo.sv */
/*
 * small staging fifo with valid/ready on both sides and a fill level.
 * assumes one clock and a synchronous active-low reset.
 */
module srf_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D+1)-1:0] level
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int LW = $clog2(D + 1);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_reg, rp_reg;
  logic [LW-1:0] cnt_reg;
  logic push, pop;

  assign in_ready = (cnt_reg != LW'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rp_reg];
  assign level = cnt_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_reg <= LW'(D)) else $error("fifo level above depth");
  a_fifo_count: assert property (@(posedge clk) disable iff (!rst_n)
    push && !pop |=> cnt_reg == $past(cnt_reg) + 1'b1) else $error("fifo level not raised");
endmodule

/* File: core/srf_rx_framer.sv */
/*
 * receive message framer: bytes from the serial line pass a staging fifo,
 * are packed into a word storage area and delimited into messages.
 * assumes bytes arrive as one-cycle strobes synchronous to clk and that the
 * host reads storage through the read port and then pulses host_done.
 */
module srf_rx_framer #(
  parameter int DEPTH = srf_pkg::FIFO_DEPTH,
  parameter int WORDS = srf_pkg::AREA_WORDS,
  parameter int PAUSE = srf_pkg::PAUSE_FREE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic [15:0] cfg_end_code,
  input wire logic [9:0] cfg_count,
  input wire logic cfg_count_bytes,
  input wire logic cfg_timeout_fmt,
  input wire logic [15:0] cfg_idle_ticks,
  input wire logic cfg_flow_dc,
  input wire logic host_done,
  input wire logic [$clog2(WORDS)-1:0] host_rd_addr,
  input wire logic err_clr,
  output logic read_request_flag,
  output logic reception_fault_flag,
  output logic serial_overrun_error,
  output logic [$clog2(WORDS):0] msg_bytes,
  output logic [15:0] host_rd_data,
  output logic dtr_out,
  output logic dc_valid,
  output logic [7:0] dc_code
);
  localparam int AW = $clog2(WORDS);
  localparam int BW = AW + 1;
  localparam int LW = $clog2(DEPTH + 1);

  srf_pkg::srf_state_e state_reg;
  logic [15:0] mem [WORDS];
  logic [BW-1:0] bcnt_reg, bcnt_next, cnt_lim;
  logic [7:0] lo_reg;
  logic cr_pend_reg;
  logic [15:0] idle_reg;
  logic [7:0] tick_reg;
  logic tick_en;
  logic f_ready, f_valid, f_pop;
  logic [7:0] f_data;
  logic [LW-1:0] f_level;
  logic code_none, code_single, hit_code, hit_cnt, hit_full;
  logic end_ok, timeout, to_request, pause, pause_reg;

  srf_fifo #(.W(8), .D(DEPTH)) u_stage (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(rx_valid),
    .in_ready(f_ready),
    .in_data(rx_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data),
    .level(f_level)
  );

  // draining stops while a message waits, so the staging fifo really fills
  assign f_pop = f_valid && (state_reg == srf_pkg::SRF_COLLECT);
  assign bcnt_next = bcnt_reg + 1'b1;

  always_comb begin
    code_none = (cfg_end_code == srf_pkg::CODE_NONE);
    code_single = (cfg_end_code[15:8] == 8'h00);
    cnt_lim = cfg_count_bytes ? BW'(cfg_count) : BW'({cfg_count, 1'b0});
    hit_code = 1'b0;
    if (!code_none) begin
      if (code_single) begin
        hit_code = (f_data == cfg_end_code[7:0]);
      end else begin
        hit_code = cr_pend_reg && (f_data == cfg_end_code[7:0]);
      end
    end
    hit_cnt = (cfg_count != 10'h000) && (bcnt_next == cnt_lim);
    // storage full always closes the message rather than wrapping
    hit_full = (bcnt_next == BW'(2 * WORDS));
    end_ok = f_pop && (hit_code || hit_cnt || hit_full);
    timeout = (state_reg == srf_pkg::SRF_COLLECT) && (bcnt_reg != '0) && !f_valid &&
      (cfg_idle_ticks != 16'h0000) && (idle_reg >= cfg_idle_ticks);
    if (code_none && cfg_count == 10'h000) begin
      to_request = 1'b1;
    end else begin
      to_request = cfg_timeout_fmt;
    end
    pause = (f_level >= LW'(DEPTH - PAUSE));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_reg <= '0;
      tick_en <= 1'b0;
    end else begin
      tick_en <= (tick_reg == 8'(srf_pkg::TICK_CYC - 1));
      tick_reg <= (tick_reg == 8'(srf_pkg::TICK_CYC - 1)) ? '0 : tick_reg + 1'b1;
    end
  end

  // idle gap timer restarts on every byte seen at the line
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_reg <= '0;
    end else if (rx_valid || state_reg != srf_pkg::SRF_COLLECT) begin
      idle_reg <= '0;
    end else if (tick_en && idle_reg != 16'hffff) begin
      idle_reg <= idle_reg + 1'b1;
    end
  end

  // pair packing; the low write pads the upper byte with zero
  always_ff @(posedge clk) begin
    if (f_pop) begin
      if (bcnt_reg[0]) begin
        mem[bcnt_reg[AW:1]] <= {f_data, lo_reg};
      end else begin
        mem[bcnt_reg[AW:1]] <= {srf_pkg::PAD_BYTE, f_data};
      end
    end
  end

  always_ff @(posedge clk) begin
    host_rd_data <= mem[host_rd_addr];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= srf_pkg::SRF_COLLECT;
      bcnt_reg <= '0;
      lo_reg <= '0;
      cr_pend_reg <= 1'b0;
      msg_bytes <= '0;
      read_request_flag <= 1'b0;
      reception_fault_flag <= 1'b0;
    end else begin
      case (state_reg)
        srf_pkg::SRF_COLLECT: begin
          if (end_ok) begin
            read_request_flag <= 1'b1;
            msg_bytes <= bcnt_next;
            state_reg <= srf_pkg::SRF_HOLD;
          end else if (f_pop) begin
            bcnt_reg <= bcnt_next;
            lo_reg <= f_data;
            cr_pend_reg <= !code_none && !code_single && (f_data == cfg_end_code[15:8]);
          end else if (timeout) begin
            read_request_flag <= to_request;
            reception_fault_flag <= !to_request;
            msg_bytes <= bcnt_reg;
            state_reg <= srf_pkg::SRF_HOLD;
          end
        end
        srf_pkg::SRF_HOLD: begin
          if (host_done) begin
            read_request_flag <= 1'b0;
            reception_fault_flag <= 1'b0;
            bcnt_reg <= '0;
            cr_pend_reg <= 1'b0;
            state_reg <= srf_pkg::SRF_COLLECT;
          end
        end
        default: begin
          state_reg <= srf_pkg::SRF_COLLECT;
        end
      endcase
    end
  end

  // a byte lost in the same cycle as the clear keeps the error set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_overrun_error <= 1'b0;
    end else if (rx_valid && !f_ready) begin
      serial_overrun_error <= 1'b1;
    end else if (err_clr) begin
      serial_overrun_error <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pause_reg <= 1'b0;
      dtr_out <= 1'b1;
      dc_valid <= 1'b0;
      dc_code <= srf_pkg::DC1_CODE;
    end else begin
      pause_reg <= pause;
      dtr_out <= cfg_flow_dc || !pause;
      dc_valid <= cfg_flow_dc && (pause != pause_reg);
      if (cfg_flow_dc && pause != pause_reg) begin
        dc_code <= pause ? srf_pkg::DC3_CODE : srf_pkg::DC1_CODE;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // flag handshake with the host
  a_req_holds: assert property (
    read_request_flag && !host_done
    |=> read_request_flag)
    else $error("read request dropped without host_done");

  a_release_done: assert property (
    state_reg == srf_pkg::SRF_HOLD && host_done
    |=> !read_request_flag && !reception_fault_flag && state_reg == srf_pkg::SRF_COLLECT)
    else $error("host_done did not release message");

  a_hold_stall: assert property (
    state_reg == srf_pkg::SRF_HOLD
    |-> !f_pop)
    else $error("staging drained while message waits");

  // message end by code
  a_single_code: assert property (
    f_pop && !code_none && code_single && f_data == cfg_end_code[7:0]
    |=> read_request_flag && msg_bytes == $past(bcnt_next))
    else $error("single end code did not end message");

  a_crlf_end: assert property (
    f_pop && !code_none && !code_single && cr_pend_reg && f_data == cfg_end_code[7:0]
    |=> read_request_flag && !reception_fault_flag)
    else $error("two-byte end code did not end message");

  a_none_nocode: assert property (
    f_pop && code_none && !hit_cnt && !hit_full
    |=> state_reg == srf_pkg::SRF_COLLECT)
    else $error("message ended with code detection off");

  a_both_code: assert property (
    f_pop && hit_code && cfg_count != 10'h000
    |=> read_request_flag)
    else $error("end code ignored while count set");

  // message end by count
  a_count_end: assert property (
    f_pop && !hit_code && cfg_count != 10'h000 && bcnt_next == cnt_lim
    |=> read_request_flag ##0 state_reg == srf_pkg::SRF_HOLD)
    else $error("count threshold did not end message");

  a_count_bytes: assert property (
    f_pop && cfg_count_bytes && cfg_count != 10'h000 && bcnt_next == BW'(cfg_count)
    |=> state_reg == srf_pkg::SRF_HOLD)
    else $error("byte count threshold did not end message");

  a_msg_bytes: assert property (
    end_ok
    |=> msg_bytes == $past(bcnt_next))
    else $error("message byte count wrong");

  // message end by idle gap; the gap is only known to within one tick
  a_timeout_kind: assert property (
    timeout && !f_pop
    |=> reception_fault_flag != read_request_flag)
    else $error("timeout raised no single flag");

  a_fault_timeout: assert property (
    !reception_fault_flag && state_reg == srf_pkg::SRF_COLLECT && !timeout
    |=> !reception_fault_flag)
    else $error("fault flag raised without timeout");

  a_no_timer_end: assert property (
    timeout && code_none && cfg_count == 10'h000
    |=> read_request_flag && !reception_fault_flag)
    else $error("idle gap end without read request");

  a_idle_restart: assert property (
    rx_valid && state_reg == srf_pkg::SRF_COLLECT
    |=> idle_reg == 16'h0000)
    else $error("idle gap timer not restarted by byte");

  a_lone_cr: assert property (
    f_pop && !end_ok
    |=> bcnt_reg == $past(bcnt_next))
    else $error("data byte not counted");

  // storage packing
  a_pair_pack: assert property (
    f_pop && bcnt_reg[0]
    |=> mem[$past(bcnt_reg[AW:1])] == {$past(f_data), $past(lo_reg)})
    else $error("byte pair packed wrongly");

  a_pad_zero: assert property (
    f_pop && !bcnt_reg[0]
    |=> mem[$past(bcnt_reg[AW:1])][15:8] == 8'h00)
    else $error("odd byte not padded with zero");

  // staging overrun and flow control
  a_overrun_set: assert property (
    rx_valid && !f_ready
    |=> serial_overrun_error)
    else $error("overrun not flagged");

  a_overrun_clear: assert property (
    serial_overrun_error && err_clr && !(rx_valid && !f_ready)
    |=> !serial_overrun_error)
    else $error("overrun not cleared");

  a_pause_dtr: assert property (
    !cfg_flow_dc && f_level == LW'(DEPTH)
    |=> !dtr_out)
    else $error("dtr not dropped when staging full");

  a_dtr_dc_mode: assert property (
    cfg_flow_dc
    |=> dtr_out)
    else $error("dtr dropped in dc flow mode");

  c_code_msg: cover property (f_pop && hit_code ##1 read_request_flag);
  c_count_msg: cover property (f_pop && hit_cnt && !hit_code ##1 read_request_flag);
  c_timeout_fault: cover property (timeout ##1 reception_fault_flag);
  c_overrun: cover property (rx_valid && !f_ready);
  c_dc3_sent: cover property (dc_valid && dc_code == srf_pkg::DC3_CODE);
endmodule

/* File: test/srf_sender.sv */
/*
 model of the serial device feeding the framer: bytes queued by send()
 leave one a cycle at the falling edge, pausing on dtr low or after dc3.
 assumes obey is high except where a bench case means to overrun.
 */
module srf_sender (
  input wire logic clk,
  input wire logic obey,
  input wire logic dtr_out,
  input wire logic dc_valid,
  input wire logic [7:0] dc_code,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  logic paused = 1'b0;
  initial rx_valid = 1'b0;
  initial rx_data = 8'h00;
  task send(input logic [7:0] b);
    q.push_back(b);
  endtask
  always @(posedge clk) begin
    if (dc_valid === 1'b1) paused <= (dc_code === srf_pkg::DC3_CODE);
  end
  // idle data is inverted each cycle so a stale byte never looks valid
  always @(negedge clk) begin
    if (q.size() > 0 && ((dtr_out === 1'b1 && !paused) || !obey)) begin
      rx_valid <= 1'b1;
      rx_data <= q.pop_front();
    end else begin
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
    end
  end
endmodule

/* File: test/tb_serial_receive_message_framer.sv */
/*
 bench for srf_rx_framer: a table of messages, then overrun and flow cases, then a mid-message reset.
 assumes srf_sender as the serial device; the bench plays the host.
 */
module tb_serial_receive_message_framer;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [15:0] code; logic [9:0] cnt; logic cb; logic fmt; logic flt; int n; logic [31:0] d;} srf_row_s;
  logic clk = 0, rst_n = 0, obey = 1, cb = 0, fmt = 0, dc = 0, done = 0, clr = 0;
  logic [15:0] code = srf_pkg::CODE_DEF;
  logic [15:0] rdata;
  logic [9:0] cnt = 0, mb;
  logic [8:0] addr = 0;
  logic rxv, req, fault, ovr, dtr, dcv;
  logic [7:0] rxd, dcc, dcs;
  int err_total = 0, n_tests = 0;
  // unused upper bytes are zero, which is also the expected pad
  srf_row_s rows [8] = '{
    '{16'h0d0a, 10'h0, 0, 0, 0, 4, 32'h0a0d4241},
    '{16'h002a, 10'h0, 0, 0, 0, 3, 32'h002a4241},
    '{16'hffff, 10'h2, 0, 0, 0, 4, 32'h44434241},
    '{16'h0023, 10'h3, 1, 0, 0, 2, 32'h00002341},
    '{16'hffff, 10'h3, 1, 0, 0, 3, 32'h00434241},
    '{16'h0d0a, 10'h0, 0, 0, 1, 3, 32'h000d4241},
    '{16'h0d0a, 10'h0, 0, 1, 0, 2, 32'h00000d41},
    '{16'hffff, 10'h0, 0, 0, 0, 2, 32'h00004241}};
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (dcv === 1'b1) dcs <= dcc;
  end
  srf_sender srf_sender_i (.clk(clk), .obey(obey), .dtr_out(dtr), .dc_valid(dcv), .dc_code(dcc),
    .rx_valid(rxv), .rx_data(rxd));
  srf_rx_framer srf_rx_framer_i (.clk(clk), .rst_n(rst_n), .rx_valid(rxv), .rx_data(rxd),
    .cfg_end_code(code), .cfg_count(cnt), .cfg_count_bytes(cb), .cfg_timeout_fmt(fmt),
    .cfg_idle_ticks(16'h0001), .cfg_flow_dc(dc), .host_done(done), .host_rd_addr(addr), .err_clr(clr),
    .read_request_flag(req), .reception_fault_flag(fault), .serial_overrun_error(ovr), .msg_bytes(mb),
    .host_rd_data(rdata), .dtr_out(dtr), .dc_valid(dcv), .dc_code(dcc));
  task print_verdict;
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task wait_end;
    int t;
    t = 0;
    while (req !== 1'b1 && fault !== 1'b1 && t < 600) begin
      @(negedge clk);
      t++;
    end
    if (t >= 600) chk(16'h0, 16'h1, "message end");
  endtask
  task rd(input logic [8:0] a, input logic [15:0] e);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk(rdata, e, "stored word");
  endtask
  // host_done only counts while a message is held, so one pulse suffices
  task ack;
    @(negedge clk);
    done = 1;
    @(negedge clk);
    done = 0;
  endtask
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    chk(req | fault | ovr | dcv, 16'h0, "flags after reset");
    chk({dtr, dcc}, 16'h0111, "flow after reset");
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      code = rows[i].code;
      cnt = rows[i].cnt;
      cb = rows[i].cb;
      fmt = rows[i].fmt;
      for (int k = 0; k < rows[i].n; k++) srf_sender_i.send(rows[i].d[8*k+:8]);
      wait_end();
      chk(fault, rows[i].flt, "fault flag");
      chk(req, !rows[i].flt, "request flag");
      chk(mb, rows[i].n, "byte count");
      for (int w = 0; w < (rows[i].n + 1) / 2; w++) rd(w, rows[i].d[16*w+:16]);
      ack();
    end
    for (int m = 0; m < 2; m++) begin
      @(negedge clk);
      dc = m;
      code = srf_pkg::CODE_DEF;
      cnt = 0;
      fmt = 1;
      srf_sender_i.send(8'h0d);
      srf_sender_i.send(8'h0a);
      wait_end();
      obey = 0;
      for (int k = 0; k < 4; k++) srf_sender_i.send(8'h43 + 8'(k));
      srf_sender_i.send(8'h0d);
      srf_sender_i.send(8'h0a);
      repeat (12) @(negedge clk);
      chk(dtr, m, "dtr while full");
      if (m) chk(dcs, srf_pkg::DC3_CODE, "pause code");
      chk(ovr, 1, "overrun");
      chk(req, 1, "request held");
      clr = 1;
      @(negedge clk);
      clr = 0;
      chk(ovr, 0, "overrun cleared");
      obey = 1;
      ack();
      wait_end();
      chk(mb, 4, "buffered message");
      rd(0, 16'h4443);
      ack();
      repeat (12) @(negedge clk);
      chk(dtr, 1, "dtr after drain");
      if (m) chk(dcs, srf_pkg::DC1_CODE, "resume code");
    end
    // a reset in mid-message drops the partial message
    code = srf_pkg::CODE_DEF;
    srf_sender_i.send(8'h41);
    repeat (3) @(negedge clk);
    rst_n = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    chk(req | fault | ovr | dcv, 16'h0, "flags after mid reset");
    srf_sender_i.send(8'h0d);
    srf_sender_i.send(8'h0a);
    wait_end();
    chk(req, 1, "request after mid reset");
    chk(mb, 2, "count after mid reset");
    rd(0, 16'h0a0d);
    ack();
    print_verdict();
  end
endmodule
